//--- design/correlator_pkg.sv
// Shared constants for the correlator score and threshold block.
// Assumes a 32-bit classic Wishbone register slave and a 7-bit score.
`default_nettype none
package correlator_pkg;

	localparam int unsigned CORR_LEN    = 64;  // Default correlation length
	localparam int unsigned SCORE_W     = 7;   // Score and threshold width
	localparam int unsigned GROUP_W     = 8;   // Bits counted per first stage
	localparam int unsigned SUM_STAGES  = 3;   // Summer pipeline depth
	localparam int unsigned WB_ADR_W    = 4;
	localparam int unsigned WB_DAT_W    = 32;

	// Register byte addresses
	localparam logic [3:0] CTRL_ADDR    = 4'h0;
	localparam logic [3:0] STATUS_ADDR  = 4'h4;

	// Control register fields
	localparam int unsigned CTRL_COMPL_BIT = 0;
	localparam logic        CTRL_COMPL_RST = 1'h0;

	// Status register fields
	localparam int unsigned STAT_SCORE_LSB = 0;
	localparam int unsigned STAT_FLAG_BIT  = 8;
	localparam int unsigned STAT_THR_LSB   = 16;

	// Reset values
	localparam logic [6:0]  SCORE_RST   = 7'h00;
	localparam logic [6:0]  THR_RST     = 7'h00;
	localparam logic        OE_N_RST    = 1'h1;

endpackage : correlator_pkg
`default_nettype wire

//--- design/correlator_score_threshold.sv
// Serial binary correlator: shift registers, pipelined summer, threshold.
// Assumes clk_i is the system clock, link_clk_i the serial clock, and a
// classic Wishbone master on the register side.
`timescale 1ns/1ps
`default_nettype none

module correlator_score_threshold #(
	parameter int unsigned WIDTH = correlator_pkg::CORR_LEN
) (
	input  wire logic                                clk_i,
	input  wire logic                                rst_i,
	// Classic Wishbone slave
	input  wire logic                                cyc_i,
	input  wire logic                                stb_i,
	input  wire logic                                we_i,
	input  wire logic [correlator_pkg::WB_ADR_W-1:0] adr_i,
	input  wire logic [3:0]                          sel_i,
	input  wire logic [correlator_pkg::WB_DAT_W-1:0] dat_i,
	output logic      [correlator_pkg::WB_DAT_W-1:0] dat_o,
	output logic                                     ack_o,
	// Serial link side
	input  wire logic                                link_clk_i,
	input  wire logic                                sample_serial_in_i,
	input  wire logic                                sample_shift_i,
	input  wire logic                                reference_serial_in_i,
	input  wire logic                                reference_shift_i,
	input  wire logic                                mask_serial_in_i,
	input  wire logic                                mask_shift_i,
	input  wire logic                                reference_hold_load_i,
	output logic                                     sample_serial_out_o,
	output logic                                     reference_serial_out_o,
	output logic                                     mask_serial_out_o,
	// Shared score and threshold bus
	input  wire logic                                threshold_clk_i,
	input  wire logic                                output_enable_n_i,
	input  wire logic [correlator_pkg::SCORE_W-1:0]  score_threshold_bus_i,
	output logic      [correlator_pkg::SCORE_W-1:0]  score_threshold_bus_o,
	output logic                                     score_threshold_bus_oe_n_o,
	output logic                                     threshold_flag_o
);
	import correlator_pkg::*;

	localparam int unsigned GROUPS = WIDTH / GROUP_W;
	localparam int unsigned HALF   = GROUPS / 2;

	// Summer tree widths are fixed by the 7-bit score
	if (WIDTH % (2 * GROUP_W) != 0 || WIDTH > CORR_LEN || WIDTH < 16) begin
		$error("WIDTH must be 16, 32, 48 or 64");
	end

	// ---------------- Link clock domain ----------------
	logic             lrst_s1_r;
	logic             lrst_s2_r;
	logic [WIDTH-1:0] sample_sr_r;
	logic [WIDTH-1:0] ref_sr_r;
	logic [WIDTH-1:0] mask_sr_r;
	logic [WIDTH-1:0] hold_r;
	logic [WIDTH-1:0] hold_nxt;
	logic [WIDTH-1:0] match;
	logic [WIDTH-1:0] snap_r;
	logic             req_r;
	logic             ack_s1_r;
	logic             ack_s2_r;
	logic             sample_out_r;
	logic             ref_out_r;
	logic             mask_out_r;
	logic             ack_tgl_r;
	wire              link_idle = (req_r == ack_s2_r);

	// Reset released into the link domain through two flops
	always_ff @(posedge link_clk_i) begin
		lrst_s1_r <= rst_i;
		lrst_s2_r <= lrst_s1_r;
	end

	// Transparent hold: follows the reference while load is high
	assign hold_nxt = reference_hold_load_i ? ref_sr_r : hold_r;
	// Equivalence gated by mask
	assign match = ~(sample_sr_r ^ hold_nxt) & mask_sr_r;

	// Independent serial shift registers
	always_ff @(posedge link_clk_i) begin
		if (lrst_s2_r) begin
			sample_sr_r <= '0;
			ref_sr_r    <= '0;
			mask_sr_r   <= '0;
			hold_r      <= '0;
		end else begin
			if (sample_shift_i) begin
				sample_sr_r <= {sample_sr_r[WIDTH-2:0], sample_serial_in_i};
			end
			if (reference_shift_i) begin
				ref_sr_r <= {ref_sr_r[WIDTH-2:0], reference_serial_in_i};
			end
			if (mask_shift_i) begin
				mask_sr_r <= {mask_sr_r[WIDTH-2:0], mask_serial_in_i};
			end
			hold_r <= hold_nxt;
		end
	end

	// Cascade outputs are registered copies of the last stage
	always_ff @(posedge link_clk_i) begin
		if (lrst_s2_r) begin
			sample_out_r <= 1'h0;
			ref_out_r    <= 1'h0;
			mask_out_r   <= 1'h0;
		end else begin
			sample_out_r <= sample_sr_r[WIDTH-1];
			ref_out_r    <= ref_sr_r[WIDTH-1];
			mask_out_r   <= mask_sr_r[WIDTH-1];
		end
	end

	// Word handshake: snapshot stays frozen until the ack toggle returns
	always_ff @(posedge link_clk_i) begin
		if (lrst_s2_r) begin
			snap_r   <= '0;
			req_r    <= 1'h0;
			ack_s1_r <= 1'h0;
			ack_s2_r <= 1'h0;
		end else begin
			ack_s1_r <= ack_tgl_r;
			ack_s2_r <= ack_s1_r;
			if (link_idle) begin
				snap_r <= match;
				req_r  <= ~req_r;
			end
		end
	end

	assign sample_serial_out_o    = sample_out_r;
	assign reference_serial_out_o = ref_out_r;
	assign mask_serial_out_o      = mask_out_r;

	// ---------------- System clock domain ----------------
	logic             req_s1_r;
	logic             req_s2_r;
	logic [WIDTH-1:0] vec_r;
	logic             thr_s1_r;
	logic             thr_s2_r;
	logic             thr_s3_r;
	logic             oe_n_s1_r;
	logic             oe_n_s2_r;
	logic [6:0]       bus_s1_r;
	logic [6:0]       bus_s2_r;
	logic [6:0]       thr_r;
	logic [6:0]       thr1_r;
	logic [6:0]       thr2_r;
	logic [3:0]       cnt1_r [GROUPS];
	logic [5:0]       lo2_r;
	logic [5:0]       hi2_r;
	logic [6:0]       score_r;
	logic [6:0]       score_nxt;
	logic [6:0]       total;
	logic             flag_r;
	logic             bus_oe_n_r;
	logic             compl_r;
	logic [31:0]      dat_r;
	logic [31:0]      rd_data;
	logic             ack_r;
	logic [5:0]       lo_sum;
	logic [5:0]       hi_sum;
	wire              new_vec  = (req_s2_r != ack_tgl_r);
	wire              thr_cap  = thr_s2_r & ~thr_s3_r & oe_n_s2_r;
	wire              wb_req   = cyc_i & stb_i;
	wire              ctrl_sel = (adr_i == CTRL_ADDR);
	wire              stat_sel = (adr_i == STATUS_ADDR);
	wire              ctrl_wr  = wb_req & ack_r & we_i & ctrl_sel & sel_i[0];

	// Pins from outside pass two flops before any logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_s1_r  <= 1'h0;
			req_s2_r  <= 1'h0;
			thr_s1_r  <= 1'h0;
			thr_s2_r  <= 1'h0;
			thr_s3_r  <= 1'h0;
			oe_n_s1_r <= OE_N_RST;
			oe_n_s2_r <= OE_N_RST;
			bus_s1_r  <= THR_RST;
			bus_s2_r  <= THR_RST;
		end else begin
			req_s1_r  <= req_r;
			req_s2_r  <= req_s1_r;
			thr_s1_r  <= threshold_clk_i;
			thr_s2_r  <= thr_s1_r;
			thr_s3_r  <= thr_s2_r; // Edge detect reads the second and third flops
			oe_n_s1_r <= output_enable_n_i;
			oe_n_s2_r <= oe_n_s1_r;
			bus_s1_r  <= score_threshold_bus_i;
			bus_s2_r  <= bus_s1_r;
		end
	end

	// Take a match vector once per handshake, then toggle the ack back
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vec_r     <= '0;
			ack_tgl_r <= 1'h0;
		end else if (new_vec) begin
			vec_r     <= snap_r;
			ack_tgl_r <= req_s2_r;
		end
	end

	// First summer stage: count groups of eight
	for (genvar g = 0; g < GROUPS; g++) begin : g_cnt
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cnt1_r[g] <= 4'h0;
			end else begin
				cnt1_r[g] <= 4'($countones(vec_r[g*GROUP_W +: GROUP_W]));
			end
		end
	end

	// Second stage adds each half of the group counts
	always_comb begin
		lo_sum = 6'h00;
		hi_sum = 6'h00;
		for (int i = 0; i < HALF; i++) begin
			lo_sum = lo_sum + 6'(cnt1_r[i]);
			hi_sum = hi_sum + 6'(cnt1_r[i+HALF]);
		end
	end

	assign total     = 7'(lo2_r) + 7'(hi2_r);
	assign score_nxt = total ^ {SCORE_W{compl_r}};

	// Summer stages two and three with the threshold beside them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lo2_r   <= 6'h00;
			hi2_r   <= 6'h00;
			thr1_r  <= THR_RST;
			thr2_r  <= THR_RST;
			score_r <= SCORE_RST;
			flag_r  <= 1'h0;
		end else begin
			lo2_r   <= lo_sum;
			hi2_r   <= hi_sum;
			thr1_r  <= thr_r;
			thr2_r  <= thr1_r;
			score_r <= score_nxt;
			flag_r  <= (total >= thr2_r);
		end
	end

	// Threshold loads only while the bus is not being driven by us
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			thr_r <= THR_RST;
		end else if (thr_cap) begin
			thr_r <= bus_s2_r;
		end
	end

	// Bus enable follows the synchronised pin, so it lags the pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_oe_n_r <= OE_N_RST;
		end else begin
			bus_oe_n_r <= oe_n_s2_r;
		end
	end

	// Read mux; unmapped addresses read zero and still acknowledge
	assign rd_data = ctrl_sel ? {31'h0, compl_r} :
	                 stat_sel ? {9'h0, thr_r, 7'h00, flag_r, 1'h0, score_r} :
	                 32'h0;

	// Wishbone: ack one cycle after the request, write at the ack edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r   <= 1'h0;
			dat_r   <= 32'h0;
			compl_r <= CTRL_COMPL_RST;
		end else begin
			ack_r <= wb_req & ~ack_r;
			dat_r <= rd_data;
			if (ctrl_wr) begin
				compl_r <= dat_i[CTRL_COMPL_BIT];
			end
		end
	end

	assign dat_o                      = dat_r;
	assign ack_o                      = ack_r;
	assign score_threshold_bus_o      = score_r;
	assign score_threshold_bus_oe_n_o = bus_oe_n_r;
	assign threshold_flag_o           = flag_r;

	// ---------------- Checks ----------------
	logic [2:0] warm_r;

	// Count cycles since reset so pipeline history is valid
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			warm_r <= 3'h0;
		end else if (warm_r != 3'h7) begin
			warm_r <= warm_r + 3'h1;
		end
	end

	AST_SCORE: assert property (@(posedge clk_i) disable iff (rst_i)
		warm_r >= 3'h4 |-> score_r ==
		(7'($countones($past(vec_r, 3))) ^ {7{$past(compl_r)}}))
		else $error("score does not match vector three cycles back");
	AST_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
		warm_r >= 3'h4 |-> flag_r ==
		(7'($countones($past(vec_r, 3))) >= $past(thr_r, 3)))
		else $error("flag not aligned with score and threshold");
	AST_THR_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
		thr_cap |=> thr_r == $past(bus_s2_r))
		else $error("threshold did not load from bus");
	AST_THR_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		!oe_n_s2_r |=> $stable(thr_r))
		else $error("threshold changed while bus driven");
	AST_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(oe_n_s2_r) |=> !score_threshold_bus_oe_n_o [*1] ##0
		score_threshold_bus_o == score_r)
		else $error("bus not driven after enable");
	AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_req && !ack_r |=> ack_o ##1 !ack_o)
		else $error("ack not a single cycle after request");
	AST_HOLD: assert property (@(posedge link_clk_i) disable iff (lrst_s2_r)
		!reference_hold_load_i |=> hold_r == $past(hold_r))
		else $error("reference hold moved while load low");
	AST_SHIFT: assert property (@(posedge link_clk_i) disable iff (lrst_s2_r)
		sample_shift_i |=> sample_sr_r[0] == $past(sample_serial_in_i) &&
		sample_sr_r[WIDTH-1:1] == $past(sample_sr_r[WIDTH-2:0]))
		else $error("sample register did not shift");
	AST_CASCADE: assert property (@(posedge link_clk_i) disable iff (lrst_s2_r)
		##1 sample_serial_out_o == $past(sample_sr_r[WIDTH-1]) &&
		reference_serial_out_o == $past(ref_sr_r[WIDTH-1]))
		else $error("cascade output mismatch");

	COV_INVERT: cover property (@(posedge clk_i) disable iff (rst_i)
		compl_r && score_r != SCORE_RST);
	COV_FLAG: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(flag_r));
	COV_THR: cover property (@(posedge clk_i) disable iff (rst_i)
		thr_cap ##1 thr_r != THR_RST);
	COV_XFER: cover property (@(posedge clk_i) disable iff (rst_i)
		new_vec && snap_r != '0);

endmodule // correlator_score_threshold
`default_nettype wire

//--- tb/accumulator_model.sv
// Far-side model: the external accumulator on the shared score bus.
// Assumes the block drives the bus only while its enable output is low.
`timescale 1ns/1ps
`default_nettype none

module accumulator_model (
	input  wire logic        clk_i,
	input  wire logic [6:0]  dev_bus_i,
	input  wire logic        dev_oe_n_i,
	output logic      [6:0]  bus_level_o,
	output logic             thr_clk_o,
	output logic             oe_n_o,
	output logic      [15:0] total_o
);
	logic [6:0] drv_r;
	logic       drv_en_r;

	// Idle: enable high, strobe low, nothing summed yet
	initial begin
		thr_clk_o = 1'h0;
		oe_n_o = 1'h1;
		total_o = 16'h0;
		drv_r = 7'h0;
		drv_en_r = 1'h0;
	end

	// Undriven bus shows the inverse of the last value, never a stale copy
	assign bus_level_o = !dev_oe_n_i ? dev_bus_i : (drv_en_r ? drv_r : ~drv_r);

	// Strobe is held three cycles high and low, well above the sync depth
	task automatic load_threshold(input logic [6:0] v, input logic en_n);
		@(posedge clk_i);
		oe_n_o <= en_n;
		drv_r <= v;
		drv_en_r <= en_n;  // Only drive while the block is off the bus
		repeat (3) @(posedge clk_i);
		thr_clk_o <= 1'h1;
		repeat (3) @(posedge clk_i);
		thr_clk_o <= 1'h0;
		repeat (3) @(posedge clk_i);
		drv_en_r <= 1'h0;
		oe_n_o <= 1'h1;
	endtask

	// One device at a time; score weighted by its bit significance
	task automatic accumulate(input int unsigned wt);
		@(posedge clk_i);
		oe_n_o <= 1'h0;
		repeat (6) @(posedge clk_i);
		total_o <= total_o + (16'(bus_level_o) << wt);
		oe_n_o <= 1'h1;
		repeat (6) @(posedge clk_i);
	endtask
endmodule // accumulator_model

`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the correlator score and threshold block.
// Assumes the accumulator model on the bus and a 16-bit correlation.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import correlator_pkg::*;
	localparam int W = 16;
	logic         clk_i = 1'h0;
	logic         link_clk_i = 1'h0;
	logic         rst_i = 1'h1;
	logic         cyc_i = 1'h0;
	logic         stb_i = 1'h0;
	logic         we_i = 1'h0;
	logic [3:0]   adr_i = 4'h0;
	logic [3:0]   sel_i = 4'h0;
	logic [3:0]   sel_v = 4'hf; // Byte selects for the next bus cycle
	logic [31:0]  dat_i = 32'h0;
	logic [31:0]  dat_o;
	logic         ack_o;
	logic [2:0]   ser_in = 3'h0; // Sample, reference, mask
	logic         shift_i = 1'h0;
	logic         load_i = 1'h1;
	wire logic [2:0] ser_out; // Three port outputs drive its bits
	logic [6:0]   bus_i;
	logic [6:0]   bus_o;
	logic         thr_clk;
	logic         oe_n;
	logic         bus_oe_n;
	logic         flag;
	logic [15:0]  total;
	logic [W-1:0] s_m = '0;
	logic [W-1:0] r_m = '0;
	logic [W-1:0] m_m = '0;
	logic [W-1:0] h_m = '0;
	logic [6:0]   thr_m = THR_RST;
	int           mismatches = 0;
	int           check_count = 0;

	// Summer runs on clk_i, so data is long settled at it
	always #10 clk_i = ~clk_i;
	initial begin
		#7;
		forever #32 link_clk_i = ~link_clk_i;
	end

	correlator_score_threshold #(.WIDTH(W)) correlator_score_threshold_i (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .link_clk_i(link_clk_i),
		.sample_serial_in_i(ser_in[2]), .sample_shift_i(shift_i),
		.reference_serial_in_i(ser_in[1]), .reference_shift_i(shift_i),
		.mask_serial_in_i(ser_in[0]), .mask_shift_i(shift_i),
		.reference_hold_load_i(load_i), .sample_serial_out_o(ser_out[2]),
		.reference_serial_out_o(ser_out[1]), .mask_serial_out_o(ser_out[0]),
		.threshold_clk_i(thr_clk), .output_enable_n_i(oe_n),
		.score_threshold_bus_i(bus_i), .score_threshold_bus_o(bus_o),
		.score_threshold_bus_oe_n_o(bus_oe_n), .threshold_flag_o(flag));

	accumulator_model accumulator_model_i (.clk_i(clk_i), .dev_bus_i(bus_o),
		.dev_oe_n_i(bus_oe_n), .bus_level_o(bus_i), .thr_clk_o(thr_clk),
		.oe_n_o(oe_n), .total_o(total));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// One classic cycle; holds everything until ack is sampled high
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		sel_i <= sel_v;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'h1); // A lost answer is left to the watchdog
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
	endtask

	function automatic logic [6:0] score_of(input logic [W-1:0] s, h, m);
		score_of = 7'h0;
		for (int i = 0; i < W; i++) score_of += 7'(~(s[i] ^ h[i]) & m[i]);
	endfunction

	// Shift whole words, oldest bit first; serial outs checked every shift
	task automatic shift_in(input logic [W-1:0] s, r, m, input logic ld);
		logic [2:0] eo;
		for (int i = 0; i <= W; i++) begin
			@(posedge link_clk_i);
			if (i > 0) begin
				eo = {s_m[W-1], r_m[W-1], m_m[W-1]};
				s_m = {s_m[W-2:0], s[W-i]};
				r_m = {r_m[W-2:0], r[W-i]};
				m_m = {m_m[W-2:0], m[W-i]};
				if (ld) h_m = r_m;
			end
			ser_in <= {s[W-1-i%W], r[W-1-i%W], m[W-1-i%W]};
			shift_i <= (i < W);
			load_i <= ld;
			@(negedge link_clk_i);
			if (i > 0) check(ser_out, eo);
		end
	endtask

	// Snapshot crossing plus three summer stages fit well inside the wait
	task automatic run(input logic [W-1:0] s, r, m, input logic ld, complement_select);
		logic [31:0] q;
		logic [6:0]  sc;
		logic [6:0]  ev;
		shift_in(s, r, m, ld);
		sc = score_of(s_m, h_m, m_m);
		ev = complement_select ? ~sc : sc;
		repeat (40) @(posedge clk_i);
		wb(1'h0, STATUS_ADDR, 32'h0, q);
		check(q[6:0], ev);
		check(bus_o, ev);
		check(q[STAT_FLAG_BIT], sc >= thr_m);
		check(flag, sc >= thr_m);
		check(q[22:16], thr_m);
	endtask

	task automatic t_regs();
		logic [31:0] q;
		check(bus_oe_n, OE_N_RST);
		wb(1'h1, 4'h8, 32'hffff_ffff, q);
		wb(1'h0, 4'h8, 32'h0, q);
		check(q, 32'h0);
		wb(1'h0, CTRL_ADDR, 32'h0, q);
		check(q, 32'(CTRL_COMPL_RST));
		// Without byte lane zero the complement select must not move
		sel_v = 4'he;
		wb(1'h1, CTRL_ADDR, 32'h1, q);
		sel_v = 4'hf;
		wb(1'h0, CTRL_ADDR, 32'h0, q);
		check(q, 32'(CTRL_COMPL_RST));
	endtask

	task automatic t_score();
		logic [31:0] q;
		run(16'hffff, 16'hffff, 16'hffff, 1'h1, 1'h0);
		run(16'ha5a5, 16'h5a5a, 16'hffff, 1'h1, 1'h0);
		run(16'h1234, 16'h1234, 16'h00ff, 1'h1, 1'h0);
		// Complement only changes the output, the flag stays on the raw count
		wb(1'h1, CTRL_ADDR, 32'h1, q);
		wb(1'h0, CTRL_ADDR, 32'h0, q);
		check(q, 32'h1);
		run(16'hf0f0, 16'hff00, 16'hffff, 1'h1, 1'h1);
		wb(1'h1, CTRL_ADDR, 32'h0, q);
	endtask

	task automatic t_thresh();
		logic [31:0] q;
		thr_m = 7'h08;
		accumulator_model_i.load_threshold(thr_m, 1'h1);
		run(16'hf0f0, 16'hff00, 16'hffff, 1'h1, 1'h0); // Equal to threshold
		run(16'hffff, 16'hffff, 16'h007f, 1'h1, 1'h0); // One below
		// Strobe while the block holds the bus must not load
		accumulator_model_i.load_threshold(7'h7f, 1'h0);
		wb(1'h1, STATUS_ADDR, 32'hffff_ffff, q);
		run(16'hffff, 16'hffff, 16'h007f, 1'h1, 1'h0);
	endtask

	// Load low keeps the old reference while a new one shifts in
	task automatic t_hold();
		run(16'hffff, 16'h0000, 16'hffff, 1'h0, 1'h0);
		run(16'hffff, 16'h0000, 16'hffff, 1'h1, 1'h0);
	endtask

	task automatic t_bus();
		logic [15:0] t0;
		run(16'hffff, 16'hffff, 16'hffff, 1'h1, 1'h0);
		t0 = total;
		accumulator_model_i.accumulate(0);
		accumulator_model_i.accumulate(2);
		check(total, t0 + 16'h0050);
		check(bus_oe_n, 1'h1);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Reset spans several link cycles so the link side sees it too
	initial begin
		repeat (4) @(posedge link_clk_i);
		@(posedge clk_i);
		rst_i <= 1'h0;
		repeat (6) @(posedge link_clk_i);
		t_regs();
		t_score();
		t_thresh();
		t_hold();
		t_bus();
		end_of_test();
	end

	// Whole run is near 20 us; a hang is cut well past that
	initial begin
		#200us;
		mismatches++;
		end_of_test();
	end
endmodule // testbench

`default_nettype wire
